// ==== verilog/bsc_consts.vh ====
// constants for the boot strap configuration capture block
`ifndef BSC_CONSTS_VH
`define BSC_CONSTS_VH

`define BSC_BOOT_NAND        2'h0
`define BSC_BOOT_EXTMEM      2'h1
`define BSC_BOOT_HOST        2'h2
`define BSC_BOOT_SERIAL      2'h3

`define BSC_STRAP_BOOT_DFLT  2'h0
`define BSC_STRAP_WIDTH_DFLT 1'h0
`define BSC_STRAP_AW_DFLT    5'h00

`define BSC_CFG_OFFSET       8'h14
`define BSC_CFG_BOOT_LSB     0
`define BSC_CFG_WIDTH_BIT    2
`define BSC_CFG_AW_LSB       3

`define BSC_ROM_VECTOR       32'h00004000
`define BSC_EXT_VECTOR       32'h02000000

`define BSC_SETUP_CYCLES     5'h10
`define BSC_STROBE_CYCLES    7'h40
`define BSC_HOLD_CYCLES      4'h8
`define BSC_ACCESS_CYCLES    7'h58

`define BSC_ADDR_PINS        22
`define BSC_FIXED_ADDR_MASK  22'h000006
`define BSC_NUM_CS           4

`endif

// ==== verilog/bsc_boot_strap_config_capture.v ====
// boot strap capture and reset-time default configuration
`timescale 1ns/100ps
`include "bsc_consts.vh"

module bsc_boot_strap_config_capture
(
	input  wire        i_clk,
	input  wire        i_reset,
	input  wire        i_global_reset_n,
	input  wire [1:0]  i_boot_select_sample_pins,
	input  wire        i_width_sample_pin,
	input  wire [4:0]  i_addr_width_sample_pins,
	input  wire        i_primary_boot_failed,
	input  wire        i_sw_cfg_we,
	input  wire        i_sw_first_cs_width,
	input  wire [4:0]  i_sw_addr_width,
	input  wire        i_sw_serial_mux_en,
	input  wire        i_sw_pll_enable,
	output reg  [7:0]  o_boot_config_capture,
	output reg         o_strap_pins_video,
	output reg         o_boot_busy,
	output reg  [31:0] o_first_fetch_vector,
	output reg         o_cfg_valid,
	output reg  [4:0]  o_pin_mux_reg_a_addr_width,
	output reg         o_pin_mux_reg_b_serial_en,
	output reg  [21:0] o_ext_addr_gpio_sel,
	output reg  [3:0]  o_cs_width_16,
	output reg         o_first_cs_nand,
	output reg         o_pll_enable,
	output reg         o_pll_bypass,
	output reg         o_dma_clk_en,
	output reg         o_ext_mem_clk_en,
	output reg         o_serial_clk_en,
	output reg  [4:0]  o_setup_cycles,
	output reg  [6:0]  o_strobe_cycles,
	output reg  [3:0]  o_hold_cycles,
	output reg  [6:0]  o_access_cycles
);

	// states of the capture sequence
	localparam [2:0] ST_HOLD = 3'b001;
	localparam [2:0] ST_LOAD = 3'b010;
	localparam [2:0] ST_RUN  = 3'b100;

	reg  [2:0] state_reg;
	reg  [2:0] state_next;
	reg        rst_n_d_reg;
	reg  [1:0] boot_reg;
	reg        width_reg;
	reg  [4:0] aw_reg;
	wire       rise;

	// address pin gpio selection for a given width field
	// upper pins beyond the enabled count stay gpio, bits 0..2 never are
	function [21:0] gpio_map;
		input [4:0] aw;
		integer k;
		begin
			gpio_map = {`BSC_ADDR_PINS{1'b1}};
			for (k = 0; k < `BSC_ADDR_PINS; k = k + 1)
				if (k < 3 + aw)
					gpio_map[k] = 1'b0;
			if (aw == 5'h00)
				gpio_map = ~`BSC_FIXED_ADDR_MASK & 22'h3FFFFE;
		end
	endfunction

	// rom vector for every code but the direct external one
	function [31:0] vector_of;
		input [1:0] sel;
		begin
			if (sel == `BSC_BOOT_EXTMEM)
				vector_of = `BSC_EXT_VECTOR;
			else
				vector_of = `BSC_ROM_VECTOR;
		end
	endfunction

	assign rise = i_global_reset_n & ~rst_n_d_reg;

	always @*
	begin
		state_next = state_reg;
		case (state_reg)
			ST_HOLD:
				if (rise)
					state_next = ST_LOAD;
			ST_LOAD:
				state_next = ST_RUN;
			ST_RUN:
				if (!i_global_reset_n)
					state_next = ST_HOLD;
			default:
				state_next = ST_HOLD;
		endcase
	end

	always @(posedge i_clk)
	begin
		if (i_reset)
		begin
			state_reg   <= ST_HOLD;
			rst_n_d_reg <= 1'b0;
			boot_reg    <= `BSC_STRAP_BOOT_DFLT;
			width_reg   <= `BSC_STRAP_WIDTH_DFLT;
			aw_reg      <= `BSC_STRAP_AW_DFLT;
		end
		else
		begin
			state_reg   <= state_next;
			rst_n_d_reg <= i_global_reset_n;
			// sample only on the release edge so later video traffic is ignored
			if (state_reg == ST_HOLD && rise)
			begin
				boot_reg  <= i_boot_select_sample_pins;
				width_reg <= i_width_sample_pin;
				aw_reg    <= i_addr_width_sample_pins;
			end
		end
	end

	// outputs: defaults while reset holds, strap-derived after capture
	always @(posedge i_clk)
	begin
		if (i_reset || state_reg == ST_HOLD)
		begin
			o_boot_config_capture      <= 8'h00;
			o_strap_pins_video         <= 1'b0;
			o_boot_busy                <= 1'b1;
			o_first_fetch_vector       <= `BSC_ROM_VECTOR;
			o_cfg_valid                <= 1'b0;
			o_pin_mux_reg_a_addr_width <= `BSC_STRAP_AW_DFLT;
			o_pin_mux_reg_b_serial_en  <= 1'b0;
			o_ext_addr_gpio_sel        <= gpio_map(5'h00);
			o_cs_width_16              <= 4'h0;
			o_first_cs_nand            <= 1'b0;
			o_pll_enable               <= 1'b0;
			o_pll_bypass               <= 1'b1;
			o_dma_clk_en               <= 1'b0;
			o_ext_mem_clk_en           <= 1'b0;
			o_serial_clk_en            <= 1'b0;
			o_setup_cycles             <= `BSC_SETUP_CYCLES;
			o_strobe_cycles            <= `BSC_STROBE_CYCLES;
			o_hold_cycles              <= `BSC_HOLD_CYCLES;
			o_access_cycles            <= `BSC_ACCESS_CYCLES;
		end
		else if (state_reg == ST_LOAD)
		begin
			o_boot_config_capture      <= {aw_reg, width_reg, boot_reg};
			o_strap_pins_video         <= 1'b1;
			o_boot_busy                <= 1'b0;
			o_first_fetch_vector       <= vector_of(boot_reg);
			o_cfg_valid                <= 1'b1;
			o_pin_mux_reg_a_addr_width <= aw_reg;
			o_pin_mux_reg_b_serial_en  <= (boot_reg == `BSC_BOOT_SERIAL);
			o_ext_addr_gpio_sel        <= gpio_map(aw_reg);
			o_cs_width_16              <= {3'h0, width_reg};
			o_first_cs_nand            <= (boot_reg == `BSC_BOOT_NAND);
			o_dma_clk_en               <= (boot_reg != `BSC_BOOT_EXTMEM);
			o_ext_mem_clk_en           <= (boot_reg == `BSC_BOOT_NAND) ||
			                              (boot_reg == `BSC_BOOT_EXTMEM);
			o_serial_clk_en            <= (boot_reg == `BSC_BOOT_SERIAL);
		end
		else
		begin
			// boot software may reshape the defaults; straps stay frozen
			if (i_primary_boot_failed)
			begin
				o_pin_mux_reg_b_serial_en <= 1'b1;
				o_serial_clk_en           <= 1'b1;
			end
			else if (i_sw_cfg_we)
				o_pin_mux_reg_b_serial_en <= i_sw_serial_mux_en;
			if (i_sw_cfg_we)
			begin
				o_cs_width_16[0]           <= i_sw_first_cs_width;
				o_pin_mux_reg_a_addr_width <= i_sw_addr_width;
				o_ext_addr_gpio_sel        <= gpio_map(i_sw_addr_width);
				o_pll_enable               <= i_sw_pll_enable;
				o_pll_bypass               <= ~i_sw_pll_enable;
			end
		end
	end

endmodule // bsc_boot_strap_config_capture

// ==== sim/bsc_props.sv ====
// checker for the boot strap capture block
`timescale 1ns/100ps
module bsc_props (
	input wire i_clk,
	input wire i_reset,
	input wire i_global_reset_n,
	input wire [1:0] i_boot_select_sample_pins,
	input wire i_width_sample_pin,
	input wire [4:0] i_addr_width_sample_pins,
	input wire [7:0] o_boot_config_capture,
	input wire o_cfg_valid,
	input wire [3:0] o_cs_width_16,
	input wire o_pll_enable,
	input wire o_pll_bypass,
	input wire o_serial_clk_en
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	AST_VALID: assert property ($rose(i_global_reset_n) ##1 i_global_reset_n [*2]
		|-> ##1 o_cfg_valid) else $error("valid late");
	AST_CAPT: assert property ($rose(o_cfg_valid) |-> o_boot_config_capture ==
		{$past(i_addr_width_sample_pins, 2), $past(i_width_sample_pin, 2),
		$past(i_boot_select_sample_pins, 2)}) else $error("bad capture");
	AST_HOLD: assert property (o_cfg_valid && $past(o_cfg_valid)
		|-> $stable(o_boot_config_capture)) else $error("capture moved");
	AST_DROP: assert property ($fell(i_global_reset_n) |-> ##2 !o_cfg_valid)
		else $error("valid kept");
	AST_CS: assert property (o_cs_width_16[3:1] == 3'h0) else $error("cs wide");
	AST_BYP: assert property (!o_cfg_valid |-> o_pll_bypass) else $error("no bypass");
	AST_PEN: assert property (!o_cfg_valid |-> !o_pll_enable) else $error("pll on");
	AST_SER: assert property (o_cfg_valid && o_boot_config_capture[1:0] == 2'h3
		|-> o_serial_clk_en) else $error("serial clock off");
endmodule // bsc_props
bind bsc_boot_strap_config_capture bsc_props bsc_props_i (.*);

// ==== sim/bsc_strap_model.sv ====
// board straps on pins shared with video outputs
`timescale 1ns/100ps
module bsc_strap_model (
	input wire i_clk,
	input wire i_video,
	input wire [7:0] i_val,
	output logic [7:0] o_pins
);
	logic [7:0] tgl = 8'h00;
	// once the pins carry video the strap levels are gone
	always @(posedge i_clk) tgl <= ~tgl;
	assign o_pins = i_video ? tgl : i_val;
endmodule // bsc_strap_model

// ==== sim/tb_top.sv ====
// self-checking bench for the boot strap capture block
`timescale 1ns/100ps
`include "bsc_consts.vh"
module tb_top;
	logic clk = 0, rst = 1, grn = 0, pbf = 0, we = 0;
	logic [7:0] sv = 8'h00, pins;
	logic [7:0] tv [4] = '{8'h00, 8'h05, 8'hFB, 8'h56};
	logic scw = 0, spe = 0;
	logic [4:0] saw = 5'h00;
	wire bsy;
	wire [4:0] stp;
	wire [6:0] stb, acc;
	wire [3:0] hld;
	wire [31:0] vec;
	wire [21:0] gp;
	wire [7:0] cap;
	wire [4:0] pma;
	wire [3:0] cs;
	wire vl, pmb, nd, pe, byp, dma, emc, ser, vid;
	int n_mismatch = 0, check_count = 0;
	bsc_strap_model bsc_strap_model_i (.i_clk(clk), .i_video(vid), .i_val(sv), .o_pins(pins));
	bsc_boot_strap_config_capture bsc_boot_strap_config_capture_i (.i_clk(clk), .i_reset(rst),
		.i_global_reset_n(grn), .i_boot_select_sample_pins(pins[1:0]),
		.i_width_sample_pin(pins[2]), .i_addr_width_sample_pins(pins[7:3]),
		.i_primary_boot_failed(pbf), .i_sw_cfg_we(we), .i_sw_first_cs_width(scw),
		.i_sw_addr_width(saw), .i_sw_serial_mux_en(1'h0), .i_sw_pll_enable(spe),
		.o_boot_config_capture(cap), .o_strap_pins_video(vid), .o_boot_busy(bsy),
		.o_first_fetch_vector(vec), .o_cfg_valid(vl), .o_pin_mux_reg_a_addr_width(pma),
		.o_pin_mux_reg_b_serial_en(pmb), .o_ext_addr_gpio_sel(gp), .o_cs_width_16(cs),
		.o_first_cs_nand(nd), .o_pll_enable(pe), .o_pll_bypass(byp), .o_dma_clk_en(dma),
		.o_ext_mem_clk_en(emc), .o_serial_clk_en(ser), .o_setup_cycles(stp),
		.o_strobe_cycles(stb), .o_hold_cycles(hld), .o_access_cycles(acc));
	task chk(input logic [31:0] g, e);
		check_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("mismatch %0t got %h", $time, g);
		end
	endtask
	task finish_test;
		if (n_mismatch == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task boot(input logic [7:0] s);
		grn = 0;
		sv = s;
		repeat (3) @(negedge clk);
		chk({vl, pe, byp, bsy, vid, gp}, {5'h06, 22'h3FFFF8});
		grn = 1;
		repeat (4) @(negedge clk);
		chk(cap, s);
		chk(vec, s[1:0] == 2'h1 ? `BSC_EXT_VECTOR : `BSC_ROM_VECTOR);
		chk({nd, dma, emc, {2{ser}}}, {s[1:0] == 2'h0, s[1:0] != 2'h1, s[1:0] < 2'h2, {2{s[1:0] == 2'h3}}});
		chk({pmb, cs, pma}, {s[1:0] == 2'h3, 3'h0, s[2], s[7:3]});
		chk(gp, ~((32'h1 << (3 + s[7:3])) - 1) & 32'h3FFFFF);
		chk({bsy, vid, stp, stb, hld, acc}, {2'h1, 5'h10, 7'h40, 4'h8, 7'h58});
	endtask
	initial forever #2.5 clk = ~clk;
	initial
	begin
		#5000;
		n_mismatch++;
		finish_test;
	end
	initial
	begin
		repeat (20) @(negedge clk);
		rst = 0;
		foreach (tv[k]) boot(tv[k]);
		we = 1;
		pbf = 1;
		scw = 1;
		spe = 1;
		saw = 5'h02;
		@(negedge clk);
		we = 0;
		pbf = 0;
		repeat (3) @(negedge clk);
		chk({cs, pmb, ser, pe, byp, pma}, {4'h1, 1'h1, 1'h1, 1'h1, 1'h0, 5'h02});
		chk(gp, 32'h3FFFE0);
		finish_test;
	end
endmodule // tb_top
